// ===== design/mt16_pkg.sv
// Purpose: Constants for the 16-bit modulo timer with AXI4-Lite registers
// Assumes: One clock aclk; register data in the low byte of each 32-bit word
// Notes:   What follows lists the block's behaviour in short form
// What this block does
// [RQ1] Counter bytes read-only, reset zero, writes ignored
// [RQ2] Counter read latches both bytes for other half
// [RQ3] Reset or clear strobe restarts read latching
// [RQ4] Debug halt freezes latches, reads return live
// [RQ5] Modulo high and low bytes read/write, reset zero
// [RQ6] Modulo zero means free-running, nonzero modulo counting
// [RQ7] Modulo programmable from one to all ones
// [RQ8] Modulo bytes buffered, copied after second byte
// [RQ9] New modulo applies at next wrap normally
// [RQ10] First modulo write after reset clears, applies
// [RQ11] Software reset applies pending modulo at once
// [RQ12] Clear strobe resets modulo byte pairing
// [RQ13] Debug halt modulo writes direct, clear counter
// [RQ14] Modulo reads return value in effect
// [RQ15] Reset: halted, zero, bus clock, divide one
// [RQ16] Clearing halt bit starts counting
// [RQ17] Source change keeps the current count
// [RQ18] Nine divide ratios, change keeps count
// [RQ19] Count per tick up to modulo, wrap
// [RQ20] Wrap flag sets on modulo to zero
// [RQ21] Flag clears by read then zero write
// [RQ22] Strobe clears flag; flag and enable interrupt
// [RQ23] Software clears flag before enabling interrupt
// [RQ24] Clear strobe zeroes counter, reads as zero
// [RQ25] Halt bit freezes count; reset sets it
// [RQ26] Source 00 bus, 01 fixed, others none
// [RQ27] Divider codes above eight divide by 256
package mt16_pkg;
    // Register byte addresses
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CLOCK  = 8'h04;
    localparam logic [7:0] OFS_CNT_HI = 8'h08;
    localparam logic [7:0] OFS_CNT_LO = 8'h0C;
    localparam logic [7:0] OFS_MOD_HI = 8'h10;
    localparam logic [7:0] OFS_MOD_LO = 8'h14;
    // Status and control field positions
    localparam int BIT_FLAG = 7;
    localparam int BIT_IE   = 6;
    localparam int BIT_CLR  = 5;
    localparam int BIT_HALT = 4;
    // Clock configuration field positions
    localparam int SRC_LSB  = 4;
    localparam int PS_LSB   = 0;
    // Encodings
    localparam logic [1:0] SRC_BUS   = 2'h0;
    localparam logic [1:0] SRC_FIXED = 2'h1;
    localparam logic [3:0] PS_MAX    = 4'h8;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Reset values
    localparam logic [15:0] RST_CNT  = 16'h0000;
    localparam logic [15:0] RST_MOD  = 16'h0000;
    localparam logic        RST_HALT = 1'h1;
    localparam logic [1:0]  RST_SRC  = 2'h0;
    localparam logic [3:0]  RST_PS   = 4'h0;
endpackage

// ===== design/mt16_timer.sv
// Purpose: 16-bit up-counting modulo timer with prescaler, AXI4-Lite slave
// Assumes: debug_halt_mode and fixed_rate_clock are asynchronous pins
// Notes:   Counting is suspended while debug halt mode is active
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module mt16_timer (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        debug_halt_mode,
    input  wire logic        fixed_rate_clock,
    output logic             wrap_irq
);
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] rbuf;
        logic        rlat;
        logic        rhi;
        logic [15:0] mbuf;
        logic        mwh;
        logic        mwl;
        logic [15:0] mpend;
        logic        mpv;
        logic [15:0] meff;
        logic        first;
        logic        flag;
        logic        arm;
        logic        ie;
        logic        halt;
        logic [1:0]  src;
        logic [3:0]  ps;
        logic [7:0]  pcnt;
        logic        dbg_s1;
        logic        dbg_s2;
        logic        fx_s1;
        logic        fx_s2;
        logic        fx_s3;
        logic        aw_h;
        logic [7:0]  waddr;
        logic        w_h;
        logic [7:0]  wdata;
        logic        wstb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [7:0]  rdata;
        logic [1:0]  rresp;
        logic        irq;
    } mt16_state_t;

    mt16_state_t st_ff;
    mt16_state_t nxt_st;

    logic        dbg;
    logic        src_tick;
    logic [3:0]  ps_eff;
    logic [8:0]  pw;
    logic [8:0]  pm9;
    logic [7:0]  pmask;
    logic        tick;
    logic        run;
    logic        at_top;
    logic        wrap_ev;
    logic        wr_go;
    logic        rd_go;
    logic [7:0]  raddr;
    logic [15:0] mval;
    logic        mdone;

    // Tick source: bus clock every cycle, fixed-rate clock on its rising edge
    assign dbg = st_ff.dbg_s2;
    assign src_tick = (st_ff.src == mt16_pkg::SRC_BUS) ? 1'b1 :                   // RQ26 RQ17
                      (st_ff.src == mt16_pkg::SRC_FIXED) ? (st_ff.fx_s2 && !st_ff.fx_s3) :
                      1'b0;

    // Divider mask; the free-running prescale count keeps the main count intact
    assign ps_eff = (st_ff.ps > mt16_pkg::PS_MAX) ? mt16_pkg::PS_MAX : st_ff.ps;     // RQ27
    assign pw     = 9'h001 << ps_eff;                                              // RQ18
    assign pm9    = pw - 9'h001;
    assign pmask  = pm9[7:0];
    assign tick   = src_tick && ((st_ff.pcnt & pmask) == pmask);

    // Wrap at modulo match, or at all ones when free-running
    assign run     = !st_ff.halt && !dbg;                                          // RQ25 RQ16
    assign at_top  = (st_ff.meff != 16'h0000) ? (st_ff.cnt == st_ff.meff) :         // RQ6 RQ7
                     (st_ff.cnt == 16'hFFFF);
    assign wrap_ev = run && tick && at_top;

    // Bus handshakes; one write and one read in flight at most
    assign wr_go = st_ff.aw_h && st_ff.w_h && !st_ff.bvalid;
    assign rd_go = s_axi_arvalid && !st_ff.rvalid;
    assign raddr = s_axi_araddr[7:0];
    assign s_axi_awready = !st_ff.aw_h;
    assign s_axi_wready  = !st_ff.w_h;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rdata   = {24'h000000, st_ff.rdata};
    assign s_axi_rresp   = st_ff.rresp;
    assign wrap_irq      = st_ff.irq;

    // Next state of the whole block
    always_comb begin
        nxt_st = st_ff;
        mval   = st_ff.mbuf;
        mdone  = 1'b0;
        // Pin synchronisers; first stage feeds only the second
        nxt_st.dbg_s1 = debug_halt_mode;
        nxt_st.dbg_s2 = st_ff.dbg_s1;
        nxt_st.fx_s1  = fixed_rate_clock;
        nxt_st.fx_s2  = st_ff.fx_s1;
        nxt_st.fx_s3  = st_ff.fx_s2;
        if (src_tick) begin
            nxt_st.pcnt = st_ff.pcnt + 8'h01;
        end
        // Counting; a pending modulo is picked up at the wrap
        if (run && tick) begin
            if (at_top) begin
                nxt_st.cnt = 16'h0000;                                             // RQ19
                if (st_ff.mpv) begin
                    nxt_st.meff = st_ff.mpend;                                     // RQ9
                    nxt_st.mpv  = 1'b0;
                end
            end else begin
                nxt_st.cnt = st_ff.cnt + 16'h0001;                                 // RQ19
            end
        end
        // Read channel
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (rd_go) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = mt16_pkg::RESP_OKAY;
            nxt_st.rdata  = 8'h00;
            unique case (raddr)
                mt16_pkg::OFS_STATUS: begin
                    nxt_st.rdata[mt16_pkg::BIT_FLAG] = st_ff.flag;
                    nxt_st.rdata[mt16_pkg::BIT_IE]   = st_ff.ie;
                    nxt_st.rdata[mt16_pkg::BIT_HALT] = st_ff.halt;                 // RQ24
                    if (st_ff.flag) begin
                        nxt_st.arm = 1'b1;                                         // RQ21
                    end
                end
                mt16_pkg::OFS_CLOCK: begin
                    nxt_st.rdata = {2'h0, st_ff.src, st_ff.ps};
                end
                mt16_pkg::OFS_CNT_HI: begin
                    if (dbg) begin
                        nxt_st.rdata = st_ff.cnt[15:8];                            // RQ4
                    end else if (st_ff.rlat && !st_ff.rhi) begin
                        nxt_st.rdata = st_ff.rbuf[15:8];                           // RQ2
                        nxt_st.rlat  = 1'b0;
                    end else begin
                        nxt_st.rdata = st_ff.cnt[15:8];
                        nxt_st.rbuf  = st_ff.cnt;                                  // RQ2
                        nxt_st.rlat  = 1'b1;
                        nxt_st.rhi   = 1'b1;
                    end
                end
                mt16_pkg::OFS_CNT_LO: begin
                    if (dbg) begin
                        nxt_st.rdata = st_ff.cnt[7:0];                             // RQ4
                    end else if (st_ff.rlat && st_ff.rhi) begin
                        nxt_st.rdata = st_ff.rbuf[7:0];                            // RQ2
                        nxt_st.rlat  = 1'b0;
                    end else begin
                        nxt_st.rdata = st_ff.cnt[7:0];
                        nxt_st.rbuf  = st_ff.cnt;                                  // RQ2
                        nxt_st.rlat  = 1'b1;
                        nxt_st.rhi   = 1'b0;
                    end
                end
                mt16_pkg::OFS_MOD_HI: nxt_st.rdata = st_ff.meff[15:8];             // RQ14
                mt16_pkg::OFS_MOD_LO: nxt_st.rdata = st_ff.meff[7:0];              // RQ14
                default: nxt_st.rresp = mt16_pkg::RESP_DECERR;
            endcase
        end
        // Write channel: address and data taken in either order
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (s_axi_awvalid && !st_ff.aw_h) begin
            nxt_st.aw_h  = 1'b1;
            nxt_st.waddr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !st_ff.w_h) begin
            nxt_st.w_h   = 1'b1;
            nxt_st.wdata = s_axi_wdata[7:0];
            nxt_st.wstb  = s_axi_wstrb[0];
        end
        if (wr_go) begin
            nxt_st.aw_h   = 1'b0;
            nxt_st.w_h    = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = mt16_pkg::RESP_OKAY;
            unique case (st_ff.waddr)
                mt16_pkg::OFS_STATUS: begin
                    if (st_ff.wstb) begin
                        nxt_st.ie   = st_ff.wdata[mt16_pkg::BIT_IE];
                        nxt_st.halt = st_ff.wdata[mt16_pkg::BIT_HALT];             // RQ25 RQ16
                        if (st_ff.wdata[mt16_pkg::BIT_CLR]) begin
                            nxt_st.cnt  = 16'h0000;                                // RQ24
                            nxt_st.flag = 1'b0;                                    // RQ22
                            nxt_st.rlat = 1'b0;                                    // RQ3
                            nxt_st.mwh  = 1'b0;                                    // RQ12
                            nxt_st.mwl  = 1'b0;
                            if (st_ff.mpv) begin
                                nxt_st.meff = st_ff.mpend;                         // RQ11 RQ24
                                nxt_st.mpv  = 1'b0;
                            end
                        end else if (!st_ff.wdata[mt16_pkg::BIT_FLAG] && st_ff.arm) begin
                            nxt_st.flag = 1'b0;                                    // RQ21
                        end
                        nxt_st.arm = 1'b0;
                    end
                end
                mt16_pkg::OFS_CLOCK: begin
                    if (st_ff.wstb) begin
                        nxt_st.src = st_ff.wdata[mt16_pkg::SRC_LSB +: 2];          // RQ17
                        nxt_st.ps  = st_ff.wdata[mt16_pkg::PS_LSB +: 4];           // RQ18
                    end
                end
                mt16_pkg::OFS_CNT_HI, mt16_pkg::OFS_CNT_LO: begin
                    nxt_st.bresp = mt16_pkg::RESP_OKAY;                            // RQ1
                end
                mt16_pkg::OFS_MOD_HI, mt16_pkg::OFS_MOD_LO: begin
                    if (st_ff.wstb && dbg) begin
                        // Debug halt: straight into the live modulo, buffer frozen
                        if (st_ff.waddr == mt16_pkg::OFS_MOD_HI) begin
                            nxt_st.meff[15:8] = st_ff.wdata;                       // RQ13
                        end else begin
                            nxt_st.meff[7:0] = st_ff.wdata;                        // RQ13
                        end
                        nxt_st.cnt = 16'h0000;                                     // RQ13
                    end else if (st_ff.wstb) begin
                        if (st_ff.waddr == mt16_pkg::OFS_MOD_HI) begin
                            mval[15:8]  = st_ff.wdata;                             // RQ8 RQ5
                            nxt_st.mwh  = 1'b1;
                            mdone       = st_ff.mwl;
                        end else begin
                            mval[7:0]   = st_ff.wdata;                             // RQ8 RQ5
                            nxt_st.mwl  = 1'b1;
                            mdone       = st_ff.mwh;
                        end
                        nxt_st.mbuf = mval;
                        if (mdone) begin
                            nxt_st.mwh = 1'b0;
                            nxt_st.mwl = 1'b0;
                            if (st_ff.first) begin
                                nxt_st.meff  = mval;                               // RQ10
                                nxt_st.cnt   = 16'h0000;                           // RQ10
                                nxt_st.first = 1'b0;
                                nxt_st.mpv   = 1'b0;
                            end else begin
                                nxt_st.mpend = mval;                               // RQ9
                                nxt_st.mpv   = 1'b1;
                            end
                        end
                    end
                end
                default: nxt_st.bresp = mt16_pkg::RESP_DECERR;
            endcase
        end
        // Set wins over any clear; a wrap also restarts the two-step clear
        if (wrap_ev) begin
            nxt_st.flag = 1'b1;                                                    // RQ20 RQ21
            nxt_st.arm  = 1'b0;
        end
        nxt_st.irq = nxt_st.flag && nxt_st.ie;                                     // RQ22
        // Synchronous reset to the documented start-up state
        if (!aresetn) begin
            nxt_st       = '0;
            nxt_st.cnt   = mt16_pkg::RST_CNT;                                      // RQ15 RQ1
            nxt_st.meff  = mt16_pkg::RST_MOD;                                      // RQ15 RQ5
            nxt_st.halt  = mt16_pkg::RST_HALT;                                     // RQ15 RQ25
            nxt_st.src   = mt16_pkg::RST_SRC;                                      // RQ15
            nxt_st.ps    = mt16_pkg::RST_PS;                                       // RQ15
            nxt_st.first = 1'b1;                                                   // RQ10 RQ3
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        st_ff <= nxt_st;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_CLR_STROBE: assert property (                                              // RQ24
        (wr_go && st_ff.waddr == mt16_pkg::OFS_STATUS && st_ff.wstb
         && st_ff.wdata[mt16_pkg::BIT_CLR] && !wrap_ev)
        |=> (st_ff.cnt == 16'h0000) && !st_ff.flag && !st_ff.rlat)
        else $error("clear strobe did not zero counter and flag");
    AST_WRAP_FLAG: assert property (                                               // RQ20
        wrap_ev |=> st_ff.flag && !st_ff.arm)
        else $error("wrap did not set flag");
    AST_HALT_FREEZE: assert property (                                             // RQ25
        (st_ff.halt && !wr_go) |=> st_ff.cnt == $past(st_ff.cnt))
        else $error("counter moved while halted");
    AST_WRAP_ZERO: assert property (                                               // RQ19
        (wrap_ev && !wr_go) |=> st_ff.cnt == 16'h0000)
        else $error("counter did not wrap to zero");
    AST_COUNT_UP: assert property (                                                // RQ19
        (run && tick && !at_top && !wr_go) |=> st_ff.cnt == $past(st_ff.cnt) + 16'h0001)
        else $error("counter did not increment");
    AST_IRQ: assert property (                                                     // RQ22
        (wrap_ev && st_ff.ie && !wr_go) |=> ##[0:1] wrap_irq)
        else $error("interrupt missing after wrap");
    AST_RESET_STATE: assert property (                                             // RQ15
        $rose(aresetn) |-> st_ff.halt && st_ff.cnt == 16'h0000 && st_ff.meff == 16'h0000
        && st_ff.src == 2'h0 && st_ff.ps == 4'h0 && !wrap_irq)
        else $error("wrong state after reset");
    AST_READ_LATCH: assert property (                                              // RQ2
        (rd_go && raddr == mt16_pkg::OFS_CNT_HI && !dbg && !(st_ff.rlat && !st_ff.rhi)
         && !wr_go) |=> st_ff.rlat && st_ff.rbuf == $past(st_ff.cnt))
        else $error("counter read did not latch");
    AST_DBG_FROZEN: assert property (                                              // RQ4
        (dbg && !wr_go) |=> $stable(st_ff.rlat) && $stable(st_ff.rbuf))
        else $error("read latch moved in debug halt");
    AST_MOD_BUFFERED: assert property (                                            // RQ8
        (wr_go && st_ff.waddr == mt16_pkg::OFS_MOD_HI && st_ff.wstb && !dbg
         && !st_ff.mwl && !wrap_ev) |=> $stable(st_ff.meff))
        else $error("single modulo byte reached live modulo");
endmodule // mt16_timer

// ===== tb/mt16_timer_test.sv
// Purpose: Self-checking bench for the modulo timer through its AXI4-Lite port
// Assumes: Design answers per its hand-over timing; tasks wait on handshakes
// Notes:   fixed_rate_clock is pulsed by hand in one scenario, held low elsewhere
`timescale 1ns/100ps
module mt16_timer_test;
    logic        aclk, aresetn, dbg, frc;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic [7:0]  d;
    int          err_count, checks, n;

    mt16_timer i_mt16_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .debug_halt_mode(dbg), .fixed_rate_clock(frc),
        .wrap_irq(irq));

    // Clock at 25 MHz
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic close_out;
        if (err_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkr(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: resp %h expected %h", $time, got, exp);
        end
    endtask

    // Write: offer address and data together, drop each when taken
    // Response ready is set high on every call and never dropped, so it stays high between calls
    task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
        int k;
        awaddr <= {24'h000000, a};
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        if (k == 50) begin
            err_count++;
            $display("mismatch at %0t: write response timed out", $time);
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [1:0] r);
        int k;
        araddr <= {24'h000000, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        v = rdata[7:0];
        r = rresp;
        if (k == 50) begin
            err_count++;
            $display("mismatch at %0t: read data timed out", $time);
        end
    endtask

    // One slow rising edge on the fixed-rate pin per count, wide enough for the syncs
    task automatic pulse(input int cnt);
        repeat (cnt) begin
            frc <= 1'b1;
            repeat (4) @(posedge aclk);
            frc <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask

    // Read one register and compare its low byte
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        rd(a, d, rsp);
        chk8(d, exp);
    endtask

    // Reset values and unmapped address
    task automatic t_reset;
        rchk(mt16_pkg::OFS_STATUS, 8'h10);
        rchk(mt16_pkg::OFS_CLOCK, 8'h00);
        rchk(mt16_pkg::OFS_CNT_HI, 8'h00);
        rchk(mt16_pkg::OFS_MOD_LO, 8'h00);
        rd(8'h18, d, rsp);
        chkr(rsp, mt16_pkg::RESP_DECERR);
        wr(8'h18, 8'hFF, rsp);
        chkr(rsp, mt16_pkg::RESP_DECERR);
    endtask

    // First modulo pair applies at once; one byte alone stays buffered
    task automatic t_mod_first;
        wr(mt16_pkg::OFS_MOD_LO, 8'h05, rsp);
        rchk(mt16_pkg::OFS_MOD_LO, 8'h00);
        wr(mt16_pkg::OFS_MOD_HI, 8'h00, rsp);
        rchk(mt16_pkg::OFS_MOD_LO, 8'h05);
        wr(mt16_pkg::OFS_CLOCK, 8'h13, rsp);
        rchk(mt16_pkg::OFS_CLOCK, 8'h13);
        wr(mt16_pkg::OFS_CLOCK, 8'h00, rsp);
    endtask

    // Wrap flag set, clear attempt spoiled by a wrap, then a clean clear
    task automatic t_flag;
        wr(mt16_pkg::OFS_STATUS, 8'h00, rsp);
        for (n = 0; n < 20; n++) begin
            rd(mt16_pkg::OFS_STATUS, d, rsp);
            if (d[7] === 1'b1) break;
        end
        chk8(d, 8'h80);
        repeat (8) @(posedge aclk);
        wr(mt16_pkg::OFS_STATUS, 8'h10, rsp);
        rchk(mt16_pkg::OFS_STATUS, 8'h90);
        wr(mt16_pkg::OFS_STATUS, 8'h10, rsp);
        rchk(mt16_pkg::OFS_STATUS, 8'h10);
    endtask

    // Pending modulo waits; clear strobe applies it and zeroes the count
    task automatic t_strobe;
        wr(mt16_pkg::OFS_MOD_HI, 8'h00, rsp);
        wr(mt16_pkg::OFS_MOD_LO, 8'h03, rsp);
        rchk(mt16_pkg::OFS_MOD_LO, 8'h05);
        wr(mt16_pkg::OFS_STATUS, 8'h30, rsp);
        rchk(mt16_pkg::OFS_MOD_LO, 8'h03);
        rchk(mt16_pkg::OFS_CNT_LO, 8'h00);
        wr(mt16_pkg::OFS_CNT_LO, 8'hFF, rsp);
        chkr(rsp, mt16_pkg::RESP_OKAY);
        rchk(mt16_pkg::OFS_CNT_LO, 8'h00);
    endtask

    // Interrupt follows flag and enable; strobe drops it
    task automatic t_irq;
        wr(mt16_pkg::OFS_STATUS, 8'h40, rsp);
        for (n = 0; n < 20 && irq !== 1'b1; n++) @(posedge aclk);
        chk8({7'h00, irq}, 8'h01);
        wr(mt16_pkg::OFS_STATUS, 8'h50, rsp);
        wr(mt16_pkg::OFS_STATUS, 8'h70, rsp);
        rchk(mt16_pkg::OFS_STATUS, 8'h50);
        chk8({7'h00, irq}, 8'h00);
    endtask

    // Debug halt: modulo byte written straight through, counter cleared
    task automatic t_debug;
        wr(mt16_pkg::OFS_STATUS, 8'h00, rsp);
        dbg <= 1'b1;
        repeat (3) @(posedge aclk);
        wr(mt16_pkg::OFS_MOD_LO, 8'h09, rsp);
        rchk(mt16_pkg::OFS_MOD_LO, 8'h09);
        rchk(mt16_pkg::OFS_CNT_LO, 8'h00);
        dbg <= 1'b0;
        @(posedge aclk);
    endtask

    // Pin source counts edges, unused source stalls, reads coherent, strobe unpairs
    task automatic t_source;
        wr(mt16_pkg::OFS_CLOCK, 8'h10, rsp);
        wr(mt16_pkg::OFS_STATUS, 8'h20, rsp);
        pulse(5);
        wr(mt16_pkg::OFS_CLOCK, 8'h20, rsp);
        pulse(2);
        wr(mt16_pkg::OFS_CLOCK, 8'h10, rsp);
        rchk(mt16_pkg::OFS_CNT_HI, 8'h00);
        pulse(2);
        rchk(mt16_pkg::OFS_CNT_LO, 8'h05);
        rchk(mt16_pkg::OFS_CNT_LO, 8'h07);
        wr(mt16_pkg::OFS_STATUS, 8'h10, rsp);
        wr(mt16_pkg::OFS_MOD_HI, 8'h01, rsp);
        wr(mt16_pkg::OFS_STATUS, 8'h30, rsp);
        wr(mt16_pkg::OFS_MOD_LO, 8'h02, rsp);
        wr(mt16_pkg::OFS_STATUS, 8'h30, rsp);
        rchk(mt16_pkg::OFS_MOD_HI, 8'h00);
    endtask

    // Watchdog against a stalled handshake
    initial begin
        #400000;
        err_count++;
        $display("mismatch at %0t: run did not finish in time", $time);
        close_out();
    end

    initial begin
        err_count = 0;
        checks = 0;
        {aresetn, dbg, frc, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
        {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
        wstrb = 4'hF;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_mod_first();
        t_flag();
        t_strobe();
        t_irq();
        t_debug();
        t_source();
        close_out();
    end
endmodule // mt16_timer_test
